// File: tsp_pkg.sv
`default_nettype none

package tsp_pkg;

  // =====================================================================
  // clock and timing
  // =====================================================================
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned MIN_LOW_NS      = 30000;
  localparam int unsigned TX_PULSE_NS     = 50000;
  // least time rounds up, never below one cycle
  localparam int unsigned MIN_LOW_CYC_RAW = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_LOW_CYC     = (MIN_LOW_CYC_RAW < 1) ? 1 : MIN_LOW_CYC_RAW;
  localparam int unsigned TX_PULSE_CYC    = (TX_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 12;

  // =====================================================================
  // register map, byte addresses
  // =====================================================================
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_CMD         = 8'h08;
  localparam logic [7:0]  OFS_PWM_PERIOD  = 8'h0c;
  localparam logic [7:0]  OFS_PWM_DUTY    = 8'h10;

  // ctrl fields
  localparam int unsigned CTRL_INV_BIT    = 0;
  localparam int unsigned CTRL_MODE_LSB   = 1;
  localparam int unsigned CTRL_SRC_LSB    = 3;
  // status fields
  localparam int unsigned ST_OUT_EN_BIT   = 0;
  localparam int unsigned ST_LEVEL_BIT    = 1;
  localparam int unsigned ST_RX_SEEN_BIT  = 2;
  localparam int unsigned ST_TX_BUSY_BIT  = 3;
  localparam int unsigned ST_PIN_BIT      = 4;
  // cmd fields
  localparam int unsigned CMD_ON_BIT      = 0;
  localparam int unsigned CMD_OFF_BIT     = 1;

  // =====================================================================
  // enumerations
  // =====================================================================
  typedef enum logic [1:0] {
    MODE_SYNC   = 2'h0,
    MODE_INPUT  = 2'h1,
    MODE_OUTPUT = 2'h2
  } tsp_mode_t;

  typedef enum logic [1:0] {
    SRC_TRUE  = 2'h0,
    SRC_FALSE = 2'h1,
    SRC_PWM   = 2'h2
  } tsp_src_t;

  // gray coded receive path: idle -> low -> done
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_LOW  = 2'h1,
    RX_DONE = 2'h3
  } tsp_rx_t;

  localparam logic [15:0] PWM_PERIOD_RST  = 16'h03e8;
  localparam logic [15:0] PWM_DUTY_RST    = 16'h01f4;

endpackage

`default_nettype wire

// File: tsp_turn_on_sync.sv
// =====================================================================
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module tsp_turn_on_sync
#(
  parameter int unsigned PWM_W = 16
)
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // front panel switch requests
  input  wire logic              panel_on,
  input  wire logic              panel_off,
  // output enable switch state
  output logic                   out_en,
  // level sampled in input mode, logic one is true
  output logic                   level_in,
  // sync pin
  input  wire logic              pin_i,
  output logic                   pin_o,
  output logic                   pin_oe
);

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    logic                       invert;
    tsp_pkg::tsp_mode_t         mode;
    tsp_pkg::tsp_src_t          src;
    logic [PWM_W-1:0]           period;
    logic [PWM_W-1:0]           duty;
    logic [PWM_W-1:0]           pwm_cnt;
    logic                       out_en;
    logic [tsp_pkg::CNT_W-1:0]  tx_cnt;
    tsp_pkg::tsp_rx_t           rx_st;
    logic [tsp_pkg::CNT_W-1:0]  rx_cnt;
    logic                       rx_seen;
    logic                       level;
    logic                       pin_o;
    logic                       pin_oe;
    logic                       wr_pend;
    logic [tsp_pkg::ADDR_W-1:0] addr;
    logic [31:0]                hrdata;
    logic                       ready;
    logic                       resp;
  } tsp_state_t;

  localparam logic [tsp_pkg::CNT_W-1:0] MIN_LOW_LAST =
    tsp_pkg::CNT_W'(tsp_pkg::MIN_LOW_CYC - 1);
  localparam logic [tsp_pkg::CNT_W-1:0] TX_LOAD =
    tsp_pkg::CNT_W'(tsp_pkg::TX_PULSE_CYC);
  localparam logic [tsp_pkg::CNT_W-1:0] CNT_ONE = {{(tsp_pkg::CNT_W-1){1'b0}}, 1'b1};
  localparam logic [PWM_W-1:0]          PWM_ONE = {{(PWM_W-1){1'b0}}, 1'b1};

  tsp_state_t s_q;
  tsp_state_t s_d;

  // =====================================================================
  // helpers
  // =====================================================================
  // pin level for a logic value: one is low unless inverted
  function automatic logic drive_level(input logic value, input logic inv);
    drive_level = ~value ^ inv;
  endfunction

  function automatic logic [31:0] read_word(input tsp_state_t st,
                                            input logic [tsp_pkg::ADDR_W-1:0] a,
                                            input logic pin);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      tsp_pkg::OFS_CTRL:
      begin
        w[tsp_pkg::CTRL_INV_BIT]                      = st.invert;
        w[tsp_pkg::CTRL_MODE_LSB +: 2]                = st.mode;
        w[tsp_pkg::CTRL_SRC_LSB +: 2]                 = st.src;
      end
      tsp_pkg::OFS_STATUS:
      begin
        w[tsp_pkg::ST_OUT_EN_BIT]                     = st.out_en;
        w[tsp_pkg::ST_LEVEL_BIT]                      = st.level;
        w[tsp_pkg::ST_RX_SEEN_BIT]                    = st.rx_seen;
        w[tsp_pkg::ST_TX_BUSY_BIT]                    = st.pin_oe & (st.mode == tsp_pkg::MODE_SYNC);
        w[tsp_pkg::ST_PIN_BIT]                        = pin;
      end
      tsp_pkg::OFS_PWM_PERIOD: w[PWM_W-1:0]            = st.period;
      tsp_pkg::OFS_PWM_DUTY:   w[PWM_W-1:0]            = st.duty;
      default:                 w                      = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction

  // =====================================================================
  // next state
  // =====================================================================
  always_comb
  begin
    logic acc;
    logic local_on;
    logic local_off;
    logic lvl;
    logic rx_valid;
    logic tx_busy;
    logic pwm_hi;
    logic out_val;

    s_d       = s_q;
    acc       = hsel & htrans[1] & hready;
    local_on  = panel_on;
    local_off = panel_off;
    rx_valid  = 1'b0;
    lvl       = 1'b0;
    tx_busy   = 1'b0;
    pwm_hi    = 1'b0;
    out_val   = 1'b0;

    // ---- bus data phase: writes land one cycle after the address ----
    if (s_q.wr_pend)
    begin
      case (s_q.addr)
        tsp_pkg::OFS_CTRL:
        begin
          s_d.invert = hwdata[tsp_pkg::CTRL_INV_BIT];
          s_d.mode   = tsp_pkg::tsp_mode_t'(hwdata[tsp_pkg::CTRL_MODE_LSB +: 2]);
          s_d.src    = tsp_pkg::tsp_src_t'(hwdata[tsp_pkg::CTRL_SRC_LSB +: 2]);
        end
        tsp_pkg::OFS_STATUS:
        begin
          // write one to clear the seen flag
          if (hwdata[tsp_pkg::ST_RX_SEEN_BIT])
          begin
            s_d.rx_seen = 1'b0;
          end
        end
        tsp_pkg::OFS_CMD:
        begin
          local_on  = panel_on | hwdata[tsp_pkg::CMD_ON_BIT];
          local_off = panel_off | hwdata[tsp_pkg::CMD_OFF_BIT];
        end
        tsp_pkg::OFS_PWM_PERIOD: s_d.period = hwdata[PWM_W-1:0];
        tsp_pkg::OFS_PWM_DUTY:   s_d.duty   = hwdata[PWM_W-1:0];
        default:
        begin
          s_d.wr_pend = 1'b0;
        end
      endcase
    end

    // ---- bus address phase ----
    s_d.wr_pend = acc & hwrite;
    s_d.addr    = haddr[tsp_pkg::ADDR_W-1:0];
    if (acc && !hwrite)
    begin
      s_d.hrdata = read_word(s_q, haddr[tsp_pkg::ADDR_W-1:0], pin_i);
    end

    // ---- receive: low excursion timed on hclk ----
    lvl     = pin_i ^ s_q.invert;
    tx_busy = (s_q.tx_cnt != '0);
    // own pulse blanks the receiver so it cannot retrigger us
    if (s_q.mode != tsp_pkg::MODE_SYNC || tx_busy)
    begin
      s_d.rx_st  = tsp_pkg::RX_IDLE;
      s_d.rx_cnt = '0;
    end
    else
    begin
      case (s_q.rx_st)
        tsp_pkg::RX_IDLE:
        begin
          if (!lvl)
          begin
            s_d.rx_st  = tsp_pkg::RX_LOW;
            s_d.rx_cnt = CNT_ONE;
          end
        end
        tsp_pkg::RX_LOW:
        begin
          if (lvl)
          begin
            s_d.rx_st  = tsp_pkg::RX_IDLE;
            s_d.rx_cnt = '0;
          end
          else if (s_q.rx_cnt >= MIN_LOW_LAST)
          begin
            s_d.rx_st = tsp_pkg::RX_DONE;
            rx_valid  = 1'b1;
          end
          else
          begin
            s_d.rx_cnt = s_q.rx_cnt + CNT_ONE;
          end
        end
        tsp_pkg::RX_DONE:
        begin
          // one pulse, one request: wait for release
          if (lvl)
          begin
            s_d.rx_st  = tsp_pkg::RX_IDLE;
            s_d.rx_cnt = '0;
          end
        end
        default:
        begin
          s_d.rx_st  = tsp_pkg::RX_IDLE;
          s_d.rx_cnt = '0;
        end
      endcase
    end

    // ---- output enable switch ----
    if (tx_busy)
    begin
      s_d.tx_cnt = s_q.tx_cnt - CNT_ONE;
    end
    if (local_off)
    begin
      s_d.out_en = 1'b0;
    end
    else if (local_on && !s_q.out_en)
    begin
      s_d.out_en = 1'b1;
      if (s_q.mode == tsp_pkg::MODE_SYNC)
      begin
        s_d.tx_cnt = TX_LOAD;
      end
    end
    else if (rx_valid && !s_q.out_en)
    begin
      s_d.out_en = 1'b1;
    end
    // a pulse while on leaves the switch alone, only the seen flag records it
    if (rx_valid)
    begin
      s_d.rx_seen = 1'b1; // set wins over a same-cycle clear
    end

    // ---- pwm ----
    if (s_q.pwm_cnt + PWM_ONE >= s_q.period)
    begin
      s_d.pwm_cnt = '0;
    end
    else
    begin
      s_d.pwm_cnt = s_q.pwm_cnt + PWM_ONE;
    end
    pwm_hi = (s_q.pwm_cnt < s_q.duty);

    // ---- pin drive ----
    case (s_q.src)
      tsp_pkg::SRC_TRUE:  out_val = 1'b1;
      tsp_pkg::SRC_FALSE: out_val = 1'b0;
      tsp_pkg::SRC_PWM:   out_val = pwm_hi;
      default:            out_val = 1'b0;
    endcase
    case (s_d.mode)
      tsp_pkg::MODE_SYNC:
      begin
        // line is shared: drive only during our own pulse
        s_d.pin_oe = (s_d.tx_cnt != '0);
        s_d.pin_o  = drive_level(1'b1, s_d.invert);
      end
      tsp_pkg::MODE_INPUT:
      begin
        s_d.pin_oe = 1'b0;
        s_d.pin_o  = 1'b0;
        s_d.level  = ~lvl;
      end
      tsp_pkg::MODE_OUTPUT:
      begin
        s_d.pin_oe = 1'b1;
        s_d.pin_o  = drive_level(out_val, s_d.invert);
      end
      default:
      begin
        s_d.pin_oe = 1'b0;
        s_d.pin_o  = 1'b0;
      end
    endcase
  end

  // =====================================================================
  // registers
  // =====================================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q         <= '0;
      s_q.mode    <= tsp_pkg::MODE_SYNC;
      s_q.src     <= tsp_pkg::SRC_TRUE;
      s_q.period  <= PWM_W'(tsp_pkg::PWM_PERIOD_RST);
      s_q.duty    <= PWM_W'(tsp_pkg::PWM_DUTY_RST);
      s_q.rx_st   <= tsp_pkg::RX_IDLE;
      s_q.ready   <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  // zero wait state slave, always okay; ready and resp are constant flops
  // so every bus output still comes from a register, also during reset
  assign hreadyout = s_q.ready;
  assign hresp     = s_q.resp;
  assign hrdata    = s_q.hrdata;
  assign out_en    = s_q.out_en;
  assign level_in  = s_q.level;
  assign pin_o     = s_q.pin_o;
  assign pin_oe    = s_q.pin_oe;

endmodule

`default_nettype wire

// File: tsp_turn_on_sync_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module tsp_turn_on_sync_assertions
(
  // bus
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  input  wire logic        hresp,
  // switch and pin
  input  wire logic        panel_on,
  input  wire logic        panel_off,
  input  wire logic        out_en,
  input  wire logic        pin_i,
  input  wire logic        pin_o,
  input  wire logic        pin_oe
);
  // =====================================================================
  // helper logic
  // =====================================================================
  logic        wr_q;
  logic [11:0] lo_q;

  // a register write may legally switch the output, so those cycles are excused
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      lo_q <= 12'h000;
    end
    else
    begin
      wr_q <= hsel && htrans[1] && hready && hwrite;
      lo_q <= pin_i ? 12'h000 : ((lo_q == 12'hfff) ? lo_q : lo_q + 12'h001);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // =====================================================================
  // properties
  // =====================================================================
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or error response");

  property p_rdata_holds;
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without a read");

  property p_panel_on;
    panel_on && !panel_off && !out_en |=> out_en;
  endproperty
  a_panel_on: assert property (p_panel_on) else $error("panel on ignored");

  property p_panel_off;
    panel_off |=> !out_en;
  endproperty
  a_panel_off: assert property (p_panel_off) else $error("panel off ignored");

  property p_hold_on;
    out_en && !panel_off && !wr_q && !$past(wr_q) |=> out_en;
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("output dropped by pin activity");

  property p_tx_pulse;
    $rose(out_en) && $rose(pin_oe) |=> (pin_oe && $stable(pin_o))[*8];
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("turn-on pulse cut short");

  property p_no_retrigger;
    pin_oe && !panel_on && !wr_q && !$past(wr_q) |=> !$rose(out_en);
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("own drive turned output on");

  property p_rx_min_width;
    $rose(out_en) && !$past(panel_on) && !$past(wr_q) && !$past(wr_q, 2) |-> lo_q >= 12'h12c;
  endproperty
  a_rx_min_width: assert property (p_rx_min_width) else $error("short low accepted");

endmodule

bind tsp_turn_on_sync tsp_turn_on_sync_assertions tsp_turn_on_sync_assertions_inst
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .panel_on(panel_on), .panel_off(panel_off), .out_en(out_en), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe(pin_oe)
);

`default_nettype wire

// File: tsp_peer_model.sv
`timescale 1ns/10ps
`default_nettype none

module tsp_peer_model
(
  // shared line
  input  wire logic clk,
  input  wire logic line,
  output logic      drv_en,
  output logic      drv_val
);
  int lo_w;
  int last_w;

  initial
  begin
    drv_en  = 1'b0;
    drv_val = 1'b1;
    lo_w    = 0;
    last_w  = 0;
  end

  // measures lows that someone else drives, so our own pulses never count
  always @(posedge clk)
  begin
    if (!line && !drv_en)
      lo_w <= lo_w + 1;
    else if (lo_w != 0)
    begin
      last_w <= lo_w;
      lo_w   <= 0;
    end
  end

  task automatic pulse(input int n);
    @(posedge clk);
    drv_en  <= 1'b1;
    drv_val <= 1'b0;
    repeat (n) @(posedge clk);
    drv_en  <= 1'b0;
  endtask

  task automatic level(input logic v);
    @(posedge clk);
    drv_en  <= 1'b1;
    drv_val <= v;
  endtask

endmodule

`default_nettype wire

// File: tsp_turn_on_sync_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tsp_turn_on_sync_tb_top;
  logic        hclk, hresetn, hsel, hwrite, panel_on, panel_off;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, out_en, level_in, pin_o, pin_oe, peer_en, peer_val;
  wire logic   hready;
  wire logic   pin_i;
  int          err_total, n_compared, k, lo;

  assign hready = hreadyout;
  // released line reads high through the pull-up
  assign pin_i  = pin_oe ? pin_o : (peer_en ? peer_val : 1'b1);

  tsp_turn_on_sync tsp_turn_on_sync_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .panel_on(panel_on), .panel_off(panel_off), .out_en(out_en), .level_in(level_in),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  tsp_peer_model tsp_peer_model_inst (.clk(hclk), .line(pin_i), .drv_en(peer_en),
    .drv_val(peer_val));

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // =====================================================================
  // tasks
  // =====================================================================
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && i < 50)
    begin
      @(posedge hclk);
      i++;
    end
    if (i >= 50)
    begin
      err_total++;
      stop_test();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic press(input logic on);
    @(posedge hclk);
    panel_on  <= on;
    panel_off <= !on;
    @(posedge hclk);
    panel_on  <= 1'b0;
    panel_off <= 1'b0;
    #1;
  endtask

  // =====================================================================
  // sequence
  // =====================================================================
  initial
  begin
    {hresetn, hsel, hwrite, panel_on, panel_off, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    chk("out_en_rst", out_en, 32'h0);
    rd_chk("ctrl_rst", tsp_pkg::OFS_CTRL, 32'h0);
    rd_chk("period_rst", tsp_pkg::OFS_PWM_PERIOD, 32'(tsp_pkg::PWM_PERIOD_RST));
    rd_chk("duty_rst", tsp_pkg::OFS_PWM_DUTY, 32'(tsp_pkg::PWM_DUTY_RST));
    rd_chk("unmapped", 8'h40, 32'h0);
    tsp_peer_model_inst.pulse(tsp_pkg::MIN_LOW_CYC - 1);
    cyc(5);
    chk("short_low", out_en, 32'h0);
    tsp_peer_model_inst.pulse(tsp_pkg::MIN_LOW_CYC);
    cyc(2);
    chk("rx_on", out_en, 32'h1);
    chk("rx_no_tx", tsp_peer_model_inst.last_w, 32'h0);
    rd_chk("status_rx", tsp_pkg::OFS_STATUS, 32'h15);
    bus(1'b1, tsp_pkg::OFS_STATUS, 32'h4);
    rd_chk("status_clr", tsp_pkg::OFS_STATUS, 32'h11);
    tsp_peer_model_inst.pulse(tsp_pkg::MIN_LOW_CYC);
    cyc(2);
    chk("rx_when_on", out_en, 32'h1);
    press(1'b0);
    chk("off", out_en, 32'h0);
    press(1'b1);
    chk("tx_drive", {pin_oe, pin_o, out_en}, 32'h5);
    cyc(tsp_pkg::TX_PULSE_CYC + 5);
    chk("tx_width", tsp_peer_model_inst.last_w, tsp_pkg::TX_PULSE_CYC);
    // software commands act like the panel switch
    bus(1'b1, tsp_pkg::OFS_CMD, 32'h2);
    cyc(1);
    chk("cmd_off", out_en, 32'h0);
    bus(1'b1, tsp_pkg::OFS_CMD, 32'h1);
    rd_chk("cmd_on", tsp_pkg::OFS_STATUS, 32'hd);
    cyc(tsp_pkg::TX_PULSE_CYC + 5);
    chk("cmd_width", tsp_peer_model_inst.last_w, tsp_pkg::TX_PULSE_CYC);
    // k[0] invert, k[1] selects the false level
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, tsp_pkg::OFS_CTRL, {27'h0, 1'b0, k[1], tsp_pkg::MODE_OUTPUT, k[0]});
      cyc(3);
      chk("static_lvl", {pin_oe, pin_o}, {30'h0, 1'b1, k[1] ^ k[0]});
    end
    bus(1'b1, tsp_pkg::OFS_PWM_PERIOD, 32'ha);
    bus(1'b1, tsp_pkg::OFS_PWM_DUTY, 32'h4);
    bus(1'b1, tsp_pkg::OFS_CTRL, {27'h0, tsp_pkg::SRC_PWM, tsp_pkg::MODE_OUTPUT, 1'b0});
    cyc(20);
    lo = 0;
    repeat (100)
    begin
      cyc(1);
      lo += (pin_o === 1'b0) ? 1 : 0;
    end
    chk("pwm_duty", lo, 32'h28);
    tsp_peer_model_inst.level(1'b0);
    bus(1'b1, tsp_pkg::OFS_CTRL, {29'h0, tsp_pkg::MODE_INPUT, 1'b0});
    cyc(3);
    chk("lvl_low", {pin_oe, level_in}, 32'h1);
    tsp_peer_model_inst.level(1'b1);
    cyc(3);
    chk("lvl_high", level_in, 32'h0);
    bus(1'b1, tsp_pkg::OFS_CTRL, {29'h0, tsp_pkg::MODE_INPUT, 1'b1});
    cyc(3);
    chk("lvl_inv", level_in, 32'h1);
    stop_test();
  end

  // hang guard
  initial
  begin
    #6000000;
    err_total++;
    stop_test();
  end

endmodule

`default_nettype wire
